// ==== logic/rrs_sequencer.sv ====
// receiver restart, gain/frequency correction start and top level mode sequencer
// assumes all event inputs come from logic on i_mclk; registers reached over AXI4-Lite
//
// Contract
// - gain/frequency correction runs once per packet after turn-on or any restart.
// - trigger field picks correction start: none, strength, preamble, or both.
// - with gain control on, frequency enable adds frequency correction at trigger.
// - with gain control off, the manual gain field is applied.
// - keep-oscillator restart acts only in receive mode, no relock.
// - relock restart restarts receiver and relocks synthesizer.
// - restart commands ignored unless mode settled flag is high.
// - auto relaunch mode 00 never restarts after a packet.
// - mode 01 restarts after payload, FIFO empty and the between-packet wait.
// - mode 10 adds a synthesizer lock delay to the automatic restart.
// - collision relaunch enabled restarts receiver on a collision at any time.
// - collision is a sudden rise of measured signal strength.
// - collision threshold is programmable in 1 dB steps.
// - launch bit starts sequencer from Sleep or Standby, recording initial mode.
// - stop bit forces the sequencer off at any time.
// - sequencer has off, idle, transmit, receive, held, low-power choice, expiry.
// - off entered from low-power choice returns chip to initial mode.
// - idle holds Standby or Sleep and only answers the first timer event.
// - transmit state keeps transmitter on, receive state keeps receiver on.
// - held state keeps receiver on with the packet in the FIFO.
// - low-power choice state is transitory, going to off or idle.
// - expiry state takes any of the three receive wait expiries.
// - idle-mode bit: 0 Standby, 1 Sleep.
// - launch route: 00 low-power choice, 01 receive, 10 transmit, 11 transmit on threshold.
// - low-power choice bit: 0 off with initial mode, 1 idle.
// - second timer event in receive always goes to low-power choice.
`timescale 1ns/1ps
module rrs_sequencer #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // axi4-lite write
  input wire logic i_awvalid,
  input wire logic [ADDR_W-1:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic i_arvalid,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // receiver and packet engine events
  input wire logic i_mode_settled_flag,
  input wire logic i_rssi_irq,
  input wire logic i_preamble_seen_irq,
  input wire logic i_sync_addr_irq,
  input wire logic i_payload_available_irq,
  input wire logic i_crc_ok_irq,
  input wire logic i_packet_sent_irq,
  input wire logic i_fifo_thresh_irq,
  input wire logic i_fifo_empty,
  input wire logic i_rssi_valid,
  input wire logic [7:0] i_rssi_value,
  input wire logic i_strength_wait_expired,
  input wire logic i_preamble_wait_expired,
  input wire logic i_syncword_wait_expired,
  input wire logic i_first_timer_event,
  input wire logic i_second_timer_event,
  // chip control
  output logic [2:0] o_chip_mode,
  output logic o_seq_active,
  output logic o_rx_restart,
  output logic o_pll_relock,
  output logic o_agc_start,
  output logic o_afc_start,
  output logic o_gain_manual,
  output logic [2:0] o_front_gain
);

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic bvld;
    logic [1:0] bresp;
    logic arrdy;
    logic rvld;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rxcfg;
    logic [31:0] seqcfg;
    logic [7:0] wait_cfg;
    rrs_pkg::rrs_seq_t st;
    logic active;
    logic fifo_wait;
    logic [2:0] mode;
    logic [2:0] init_mode;
    logic restart;
    logic relock;
    logic ar_armed;
    logic ar_count;
    logic ar_lock;
    logic [15:0] cnt;
    logic corr_armed;
    logic rssi_seen;
    logic pre_seen;
    logic agc_go;
    logic afc_go;
    logic manual;
    logic [2:0] gain;
    logic [7:0] rssi_prev;
  } rrs_state_t;

  rrs_state_t s_ff;
  rrs_state_t nxt_s;
  logic wr_fire;
  logic cw_launch;
  logic cw_stop;
  logic cw_keep;
  logic cw_relock;
  logic launch_ok;
  logic rx_mode;
  logic collide;
  logic fire;

  function automatic logic [31:0] rrs_merge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] m);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (m[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.restart = 1'h0;
    nxt_s.relock = 1'h0;
    nxt_s.agc_go = 1'h0;
    nxt_s.afc_go = 1'h0;
    rx_mode = s_ff.mode == rrs_pkg::MODE_RX;
    wr_fire = s_ff.aw_got && s_ff.w_got;
    // trigger bits are acted on in the write cycle only and never stored
    cw_launch = wr_fire && s_ff.awaddr == rrs_pkg::REG_CTRL && s_ff.wstrb[0] &&
                s_ff.wdata[rrs_pkg::CTL_LAUNCH];
    cw_stop = wr_fire && s_ff.awaddr == rrs_pkg::REG_CTRL && s_ff.wstrb[0] &&
              s_ff.wdata[rrs_pkg::CTL_STOP];
    cw_keep = wr_fire && s_ff.awaddr == rrs_pkg::REG_CTRL && s_ff.wstrb[0] &&
              s_ff.wdata[rrs_pkg::CTL_KEEP];
    cw_relock = wr_fire && s_ff.awaddr == rrs_pkg::REG_CTRL && s_ff.wstrb[0] &&
                s_ff.wdata[rrs_pkg::CTL_RELOCK];
    launch_ok = !s_ff.active && (s_ff.mode == rrs_pkg::MODE_SLEEP ||
                                 s_ff.mode == rrs_pkg::MODE_STDBY);
    collide = s_ff.rxcfg[rrs_pkg::RXC_COLL] && rx_mode && i_rssi_valid &&
              {1'h0, i_rssi_value} > {1'h0, s_ff.rssi_prev} +
              {1'h0, s_ff.rxcfg[rrs_pkg::RXC_STEP +: 8]};
    fire = 1'h0;

    // bus: address and data taken in either order, answered once both are in
    if (i_awvalid && s_ff.awrdy)
    begin
      nxt_s.aw_got = 1'h1;
      nxt_s.awrdy = 1'h0;
      nxt_s.awaddr = 8'(i_awaddr);
    end
    if (i_wvalid && s_ff.wrdy)
    begin
      nxt_s.w_got = 1'h1;
      nxt_s.wrdy = 1'h0;
      nxt_s.wdata = i_wdata;
      nxt_s.wstrb = i_wstrb;
    end
    if (wr_fire)
    begin
      nxt_s.aw_got = 1'h0;
      nxt_s.w_got = 1'h0;
      nxt_s.bvld = 1'h1;
      nxt_s.bresp = rrs_pkg::RESP_OK;
      unique case (s_ff.awaddr)
        rrs_pkg::REG_CTRL:
          ;
        rrs_pkg::REG_RXCFG:
          nxt_s.rxcfg = rrs_merge(s_ff.rxcfg, s_ff.wdata, s_ff.wstrb);
        rrs_pkg::REG_SEQCFG:
          nxt_s.seqcfg = rrs_merge(s_ff.seqcfg, s_ff.wdata, s_ff.wstrb);
        rrs_pkg::REG_WAIT:
          if (s_ff.wstrb[0])
          begin
            nxt_s.wait_cfg = s_ff.wdata[7:0];
          end
        rrs_pkg::REG_MODE:
          // manual mode writes are locked out while the sequencer owns the chip
          if (s_ff.wstrb[0] && !s_ff.active)
          begin
            nxt_s.mode = s_ff.wdata[2:0];
          end
        rrs_pkg::REG_STAT:
          ;
        default:
          nxt_s.bresp = rrs_pkg::RESP_ERR;
      endcase
    end
    if (s_ff.bvld && i_bready)
    begin
      nxt_s.bvld = 1'h0;
      nxt_s.awrdy = 1'h1;
      nxt_s.wrdy = 1'h1;
    end
    if (i_arvalid && s_ff.arrdy)
    begin
      nxt_s.arrdy = 1'h0;
      nxt_s.rvld = 1'h1;
      nxt_s.rresp = rrs_pkg::RESP_OK;
      unique case (8'(i_araddr))
        rrs_pkg::REG_CTRL:
          nxt_s.rdata = '0;
        rrs_pkg::REG_RXCFG:
          nxt_s.rdata = s_ff.rxcfg;
        rrs_pkg::REG_SEQCFG:
          nxt_s.rdata = s_ff.seqcfg;
        rrs_pkg::REG_WAIT:
          nxt_s.rdata = {24'h0, s_ff.wait_cfg};
        rrs_pkg::REG_MODE:
          nxt_s.rdata = {29'h0, s_ff.mode};
        rrs_pkg::REG_STAT:
          nxt_s.rdata = {23'h0, s_ff.ar_count, s_ff.ar_armed, s_ff.corr_armed,
                         s_ff.fifo_wait, i_mode_settled_flag, s_ff.active, s_ff.st};
        default:
        begin
          nxt_s.rdata = '0;
          nxt_s.rresp = rrs_pkg::RESP_ERR;
        end
      endcase
    end
    if (s_ff.rvld && i_rready)
    begin
      nxt_s.rvld = 1'h0;
      nxt_s.arrdy = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    unique case (s_ff.st)
      rrs_pkg::ST_OFF:
        if (s_ff.fifo_wait && i_fifo_thresh_irq)
        begin
          nxt_s.st = rrs_pkg::ST_TX;
          nxt_s.fifo_wait = 1'h0;
        end
      rrs_pkg::ST_IDLE:
        if (i_first_timer_event)
        begin
          nxt_s.st = s_ff.seqcfg[rrs_pkg::SQ_FIDLE] ? rrs_pkg::ST_RX : rrs_pkg::ST_TX;
        end
      rrs_pkg::ST_TX:
        if (i_packet_sent_irq)
        begin
          nxt_s.st = s_ff.seqcfg[rrs_pkg::SQ_FTX] ? rrs_pkg::ST_RX : rrs_pkg::ST_LPSEL;
        end
      rrs_pkg::ST_RX:
        if (i_second_timer_event)
        begin
          nxt_s.st = rrs_pkg::ST_LPSEL;
        end
        else if (i_strength_wait_expired || i_preamble_wait_expired || i_syncword_wait_expired)
        begin
          nxt_s.st = rrs_pkg::ST_EXPIRY;
        end
        else
        begin
          unique case (s_ff.seqcfg[rrs_pkg::SQ_FRX +: 3])
            3'h1:
              if (i_payload_available_irq) nxt_s.st = rrs_pkg::ST_HELD;
            3'h2:
              if (i_payload_available_irq) nxt_s.st = rrs_pkg::ST_LPSEL;
            3'h3:
              if (i_crc_ok_irq) nxt_s.st = rrs_pkg::ST_HELD;
              else if (i_payload_available_irq) nxt_s.st = rrs_pkg::ST_EXPIRY;
            3'h4:
              if (i_rssi_irq) nxt_s.st = rrs_pkg::ST_OFF;
            3'h5:
              if (i_sync_addr_irq) nxt_s.st = rrs_pkg::ST_OFF;
            3'h6:
              if (i_preamble_seen_irq) nxt_s.st = rrs_pkg::ST_OFF;
            default:
              ;
          endcase
        end
      rrs_pkg::ST_HELD:
        // packet stays in the FIFO until the period timer ends the slot
        if (i_second_timer_event)
        begin
          nxt_s.st = rrs_pkg::ST_LPSEL;
        end
      rrs_pkg::ST_LPSEL:
        nxt_s.st = s_ff.seqcfg[rrs_pkg::SQ_LPCH] ? rrs_pkg::ST_IDLE : rrs_pkg::ST_OFF;
      rrs_pkg::ST_EXPIRY:
        nxt_s.st = rrs_pkg::ST_LPSEL;
      default:
        nxt_s.st = rrs_pkg::ST_OFF;
    endcase
    if (cw_launch && launch_ok)
    begin
      nxt_s.active = 1'h1;
      nxt_s.init_mode = s_ff.mode;
      unique case (s_ff.seqcfg[rrs_pkg::SQ_ROUTE +: 2])
        2'h0: nxt_s.st = rrs_pkg::ST_LPSEL;
        2'h1: nxt_s.st = rrs_pkg::ST_RX;
        2'h2: nxt_s.st = rrs_pkg::ST_TX;
        2'h3: nxt_s.fifo_wait = 1'h1;
      endcase
    end
    if (s_ff.active && nxt_s.st == rrs_pkg::ST_OFF && s_ff.st != rrs_pkg::ST_OFF)
    begin
      nxt_s.active = 1'h0;
    end
    // stop overrides everything the sequencer would do in this cycle
    if (cw_stop)
    begin
      nxt_s.st = rrs_pkg::ST_OFF;
      nxt_s.active = 1'h0;
      nxt_s.fifo_wait = 1'h0;
    end
    if (nxt_s.st != s_ff.st)
    begin
      unique case (nxt_s.st)
        rrs_pkg::ST_OFF: nxt_s.mode = s_ff.init_mode;
        rrs_pkg::ST_IDLE:
          nxt_s.mode = s_ff.seqcfg[rrs_pkg::SQ_IDLE] ? rrs_pkg::MODE_SLEEP : rrs_pkg::MODE_STDBY;
        rrs_pkg::ST_TX: nxt_s.mode = rrs_pkg::MODE_TX;
        rrs_pkg::ST_RX, rrs_pkg::ST_HELD: nxt_s.mode = rrs_pkg::MODE_RX;
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver restart
    if (i_rssi_valid)
    begin
      nxt_s.rssi_prev = i_rssi_value;
    end
    if (s_ff.rxcfg[rrs_pkg::RXC_AUTO +: 2] != rrs_pkg::AUTO_OFF && rx_mode &&
        i_payload_available_irq)
    begin
      nxt_s.ar_armed = 1'h1;
    end
    if (s_ff.ar_armed && !s_ff.ar_count && i_fifo_empty)
    begin
      nxt_s.ar_count = 1'h1;
      nxt_s.ar_lock = s_ff.rxcfg[rrs_pkg::RXC_AUTO +: 2] == rrs_pkg::AUTO_NEWFREQ;
      nxt_s.cnt = 16'(s_ff.wait_cfg * rrs_pkg::WAIT_UNIT_CYC);
      if (nxt_s.ar_lock)
      begin
        nxt_s.cnt = 16'(nxt_s.cnt + rrs_pkg::RELOCK_CYC);
      end
    end
    if (s_ff.ar_count)
    begin
      nxt_s.cnt = s_ff.cnt - 16'h1;
      if (s_ff.cnt == 16'h0)
      begin
        nxt_s.restart = 1'h1;
        nxt_s.relock = s_ff.ar_lock;
      end
    end
    if ((cw_keep || cw_relock) && i_mode_settled_flag && rx_mode)
    begin
      nxt_s.restart = 1'h1;
      nxt_s.relock = cw_relock;
    end
    if (collide)
    begin
      nxt_s.restart = 1'h1;
    end
    if (nxt_s.restart || nxt_s.mode != rrs_pkg::MODE_RX)
    begin
      nxt_s.ar_armed = 1'h0;
      nxt_s.ar_count = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction start, once per packet
    if (s_ff.corr_armed)
    begin
      nxt_s.rssi_seen = s_ff.rssi_seen || i_rssi_irq;
      nxt_s.pre_seen = s_ff.pre_seen || i_preamble_seen_irq;
      unique case (s_ff.rxcfg[rrs_pkg::RXC_TRIG +: 3])
        rrs_pkg::TRIG_RSSI: fire = i_rssi_irq;
        rrs_pkg::TRIG_PRE: fire = i_preamble_seen_irq;
        rrs_pkg::TRIG_BOTH: fire = nxt_s.rssi_seen && nxt_s.pre_seen;
        default: fire = 1'h0;
      endcase
    end
    if (fire)
    begin
      nxt_s.corr_armed = 1'h0;
      nxt_s.agc_go = s_ff.rxcfg[rrs_pkg::RXC_AGC];
      nxt_s.afc_go = s_ff.rxcfg[rrs_pkg::RXC_AGC] && s_ff.rxcfg[rrs_pkg::RXC_AFC];
    end
    if (nxt_s.restart || (nxt_s.mode == rrs_pkg::MODE_RX && !rx_mode))
    begin
      nxt_s.corr_armed = 1'h1;
      nxt_s.rssi_seen = 1'h0;
      nxt_s.pre_seen = 1'h0;
    end
    if (nxt_s.restart)
    begin
      // stale strength from before the restart must not read as a collision
      nxt_s.rssi_prev = rrs_pkg::RSSI_RST;
    end
    nxt_s.manual = !s_ff.rxcfg[rrs_pkg::RXC_AGC];
    nxt_s.gain = s_ff.rxcfg[rrs_pkg::RXC_AGC] ? 3'h0 : s_ff.rxcfg[rrs_pkg::RXC_GAIN +: 3];
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_ff <= '0;
      s_ff.awrdy <= 1'h1;
      s_ff.wrdy <= 1'h1;
      s_ff.arrdy <= 1'h1;
      s_ff.rxcfg <= rrs_pkg::RXCFG_RST;
      s_ff.seqcfg <= rrs_pkg::SEQCFG_RST;
      s_ff.wait_cfg <= rrs_pkg::WAIT_RST;
      s_ff.rssi_prev <= rrs_pkg::RSSI_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign o_awready = s_ff.awrdy;
  assign o_wready = s_ff.wrdy;
  assign o_bvalid = s_ff.bvld;
  assign o_bresp = s_ff.bresp;
  assign o_arready = s_ff.arrdy;
  assign o_rvalid = s_ff.rvld;
  assign o_rdata = s_ff.rdata;
  assign o_rresp = s_ff.rresp;
  assign o_chip_mode = s_ff.mode;
  assign o_seq_active = s_ff.active;
  assign o_rx_restart = s_ff.restart;
  assign o_pll_relock = s_ff.relock;
  assign o_agc_start = s_ff.agc_go;
  assign o_afc_start = s_ff.afc_go;
  assign o_gain_manual = s_ff.manual;
  assign o_front_gain = s_ff.gain;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_launch_rx;
    cw_launch && launch_ok && s_ff.seqcfg[rrs_pkg::SQ_ROUTE +: 2] == 2'h1;
  endsequence

  sequence s_rx_period_end;
    s_ff.st == rrs_pkg::ST_RX && i_second_timer_event && !cw_stop;
  endsequence

  a_restart_needs_ready: assert property ((cw_keep || cw_relock) && !i_mode_settled_flag && !collide &&
    !s_ff.ar_count |=> !o_rx_restart) else $error("restart taken without mode settled");
  a_relock_cmd: assert property (cw_relock && i_mode_settled_flag && rx_mode |=> o_rx_restart && o_pll_relock)
    else $error("relock restart not issued");
  a_stop_off: assert property (cw_stop |=> s_ff.st == rrs_pkg::ST_OFF && !o_seq_active)
    else $error("stop did not halt sequencer");
  a_launch_route: assert property (s_launch_rx |=> s_ff.st == rrs_pkg::ST_RX && o_chip_mode == rrs_pkg::MODE_RX)
    else $error("launch route to receive failed");
  a_timer_two_exit: assert property (s_rx_period_end |=> s_ff.st == rrs_pkg::ST_LPSEL ##1
    s_ff.st inside {rrs_pkg::ST_OFF, rrs_pkg::ST_IDLE}) else $error("receive did not leave on timer");
  a_idle_mode: assert property ($changed(s_ff.st) && s_ff.st == rrs_pkg::ST_IDLE |->
    o_chip_mode == (s_ff.seqcfg[rrs_pkg::SQ_IDLE] ? rrs_pkg::MODE_SLEEP : rrs_pkg::MODE_STDBY))
    else $error("idle mode wrong");
  a_collision_kick: assert property (collide |=> o_rx_restart && o_agc_start == 1'h0 ##1 s_ff.corr_armed ||
    o_rx_restart) else $error("collision did not restart");
  a_trig_none: assert property (s_ff.rxcfg[rrs_pkg::RXC_TRIG +: 3] == 3'h0 && $stable(s_ff.rxcfg) |=> !o_agc_start)
    else $error("correction started with no trigger");
  a_afc_needs_agc: assert property (o_afc_start |-> o_agc_start && $past(s_ff.rxcfg[rrs_pkg::RXC_AGC]))
    else $error("frequency correction without gain control");
  a_manual_gain: assert property (!s_ff.rxcfg[rrs_pkg::RXC_AGC] && $stable(s_ff.rxcfg) |=>
    o_gain_manual && o_front_gain == $past(s_ff.rxcfg[rrs_pkg::RXC_GAIN +: 3])) else $error("manual gain lost");

endmodule

// ==== logic/rrs_pkg.sv ====
// constants, register map and state codes of the receiver restart and mode sequencer
// assumes a 40 MHz i_mclk; all users write rrs_pkg::name
package rrs_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RXCFG = 8'h04;
  localparam logic [7:0] REG_SEQCFG = 8'h08;
  localparam logic [7:0] REG_WAIT = 8'h0C;
  localparam logic [7:0] REG_MODE = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  // control trigger bits, all self-clearing
  localparam int CTL_LAUNCH = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_KEEP = 2;
  localparam int CTL_RELOCK = 3;
  // receiver_config_reg fields
  localparam int RXC_TRIG = 0;
  localparam int RXC_AGC = 3;
  localparam int RXC_AFC = 4;
  localparam int RXC_COLL = 5;
  localparam int RXC_GAIN = 6;
  localparam int RXC_AUTO = 9;
  localparam int RXC_STEP = 12;
  // seq_config_reg_a fields
  localparam int SQ_IDLE = 0;
  localparam int SQ_ROUTE = 1;
  localparam int SQ_LPCH = 3;
  localparam int SQ_FIDLE = 4;
  localparam int SQ_FTX = 5;
  localparam int SQ_FRX = 6;
  // values after reset
  localparam logic [31:0] RXCFG_RST = 32'h0000_0008;
  localparam logic [31:0] SEQCFG_RST = 32'h0000_0000;
  localparam logic [7:0] WAIT_RST = 8'h00;
  localparam logic [7:0] RSSI_RST = 8'hFF;
  // chip operating modes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h5;
  // correction_trigger_select codes
  localparam logic [2:0] TRIG_RSSI = 3'h1;
  localparam logic [2:0] TRIG_PRE = 3'h6;
  localparam logic [2:0] TRIG_BOTH = 3'h7;
  // auto_rx_relaunch_mode codes
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_NEWFREQ = 2'h2;
  // bus responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // timing
  localparam int CLK_NS = 25;
  localparam int RELOCK_NS = 60000;
  localparam int WAIT_UNIT_NS = 1000;
  localparam logic [15:0] RELOCK_CYC = 16'((RELOCK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WAIT_UNIT_CYC = 16'((WAIT_UNIT_NS + CLK_NS - 1) / CLK_NS);
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_IDLE = 3'h1,
    ST_TX = 3'h2,
    ST_RX = 3'h3,
    ST_HELD = 3'h4,
    ST_LPSEL = 3'h5,
    ST_EXPIRY = 3'h6
  } rrs_seq_t;
endpackage

// ==== tb/rrs_radio_model.sv ====
// radio front end as seen by the sequencer: reports when the chip mode has settled
// assumes it is clocked by i_mclk and watches the sequencer's chip mode output
`timescale 1ns/1ps
module rrs_radio_model #(
  parameter int LAG = 3
) (
  // clock
  input wire logic i_mclk,
  // chip side
  input wire logic [2:0] i_chip_mode,
  input wire logic i_hold,
  // flag back to the sequencer
  output logic o_mode_settled_flag
);
  logic [2:0] last_ff = 3'h0;
  int cnt_ff = 0;
  // a new mode needs LAG+1 cycles; i_hold models a slow chip that never settles
  always @(posedge i_mclk)
  begin
    cnt_ff <= (i_chip_mode !== last_ff) ? 0 : (cnt_ff < LAG ? cnt_ff + 1 : cnt_ff);
    last_ff <= i_chip_mode;
  end
  assign o_mode_settled_flag = !i_hold && cnt_ff >= LAG && i_chip_mode === last_ff;
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the restart and mode sequencer over AXI4-Lite
// assumes the radio model supplies the settled flag; events are pulsed by the bench
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic i_mclk = 0, i_resetn = 0, aw = 0, wv = 0, ar = 0, bready = 0, rready = 0, hold = 0, rv = 0, settled;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rssi = 8'h00;
  logic fe = 1'b1;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic [11:0] ev = 12'h000;
  logic [2:0] mode, fgain;
  logic [1:0] resp, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, active, rst, relock, agc, afc, gman;
  int mismatches = 0, samples_checked = 0, n_rst = 0, n_rl = 0, n_agc = 0, n_afc = 0, s0, s1;
  always #12.5 i_mclk = ~i_mclk;
  // pulses are counted at the edge that samples them
  always @(posedge i_mclk)
  begin
    n_rst += (rst === 1'b1);
    n_rl += (relock === 1'b1);
    n_agc += (agc === 1'b1);
    n_afc += (afc === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  rrs_sequencer uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_awvalid(aw), .i_awaddr(awaddr),
    .o_awready(awready), .i_wvalid(wv), .i_wdata(wdata), .i_wstrb(4'hF), .o_wready(wready),
    .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready), .i_arvalid(ar), .i_araddr(araddr),
    .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready),
    .i_mode_settled_flag(settled), .i_rssi_irq(ev[0]), .i_preamble_seen_irq(ev[1]),
    .i_sync_addr_irq(ev[2]), .i_payload_available_irq(ev[3]), .i_crc_ok_irq(ev[4]),
    .i_packet_sent_irq(ev[5]), .i_fifo_thresh_irq(ev[6]), .i_fifo_empty(fe), .i_rssi_valid(rv),
    .i_rssi_value(rssi), .i_strength_wait_expired(ev[7]), .i_preamble_wait_expired(ev[8]),
    .i_syncword_wait_expired(ev[9]), .i_first_timer_event(ev[10]), .i_second_timer_event(ev[11]),
    .o_chip_mode(mode), .o_seq_active(active), .o_rx_restart(rst), .o_pll_relock(relock),
    .o_agc_start(agc), .o_afc_start(afc), .o_gain_manual(gman), .o_front_gain(fgain));
  rrs_radio_model #(.LAG(3)) radio (.i_mclk(i_mclk), .i_chip_mode(mode), .i_hold(hold),
    .o_mode_settled_flag(settled));
  ////////////////////////////////////////////////////////////////////////
  task test_done;
  begin
    $display("samples_checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task tick(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  // outputs read just after an edge still hold the value sampled at that edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    aw <= 1'b1; wv <= 1'b1; awaddr <= a; wdata <= d; bready <= 1'b1;
    do begin @(posedge i_mclk); n++; if (awready) aw <= 1'b0; if (wready) wv <= 1'b0; end
    while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    if (n >= 50) begin mismatches++; test_done; end
  end
  endtask
  task rdr(input logic [7:0] a);
    int n;
  begin
    n = 0;
    ar <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin @(posedge i_mclk); n++; if (arready) ar <= 1'b0; end
    while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    resp = rresp;
    if (n >= 50) begin mismatches++; test_done; end
  end
  endtask
  task pulse(input int i);
  begin
    ev[i] <= 1'b1; @(posedge i_mclk); ev[i] <= 1'b0; tick(3);
  end
  endtask
  task sample(input logic [7:0] v);
  begin
    rv <= 1'b1; rssi <= v; @(posedge i_mclk); rv <= 1'b0; tick(3);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(2);
    i_resetn <= 1'b1;
    tick(1);
    rdr(rrs_pkg::REG_RXCFG); `CHK(rd, rrs_pkg::RXCFG_RST)
    rdr(8'h18); `CHK(resp, rrs_pkg::RESP_ERR)
    $display("test reset done");
    wr(8'h18, 32'h0000_0000); `CHK(resp, rrs_pkg::RESP_ERR)
    wr(rrs_pkg::REG_SEQCFG, 32'h0000_0002); `CHK(resp, rrs_pkg::RESP_OK)
    wr(rrs_pkg::REG_RXCFG, 32'h0000_3039);
    wr(rrs_pkg::REG_CTRL, 32'h0000_0001); `CHK(mode, rrs_pkg::MODE_RX)
    tick(6);
    rdr(rrs_pkg::REG_CTRL); `CHK(rd, 32'h0000_0000)
    s0 = n_rst; s1 = n_rl;
    wr(rrs_pkg::REG_CTRL, 32'h0000_0004); tick(3); `CHK(n_rst, s0 + 1)
    `CHK(n_rl, s1)
    wr(rrs_pkg::REG_CTRL, 32'h0000_0008); tick(3); `CHK(n_rl, s1 + 1)
    hold <= 1'b1;
    wr(rrs_pkg::REG_CTRL, 32'h0000_0008); tick(3); `CHK(n_rst, s0 + 2)
    hold <= 1'b0;
    $display("test restart done");
    s0 = n_agc; s1 = n_afc;
    pulse(0); `CHK(n_agc, s0 + 1)
    `CHK(n_afc, s1 + 1)
    pulse(0); `CHK(n_agc, s0 + 1)
    $display("test correction done");
    sample(8'h14);
    s0 = n_rst;
    sample(8'h17); `CHK(n_rst, s0)
    sample(8'h1B); `CHK(n_rst, s0 + 1)
    $display("test collision done");
    pulse(11); `CHK(mode, rrs_pkg::MODE_SLEEP)
    rdr(rrs_pkg::REG_STAT); `CHK(rd[3:0], 4'h0)
    wr(rrs_pkg::REG_SEQCFG, 32'h0000_0004);
    wr(rrs_pkg::REG_CTRL, 32'h0000_0001); `CHK(mode, rrs_pkg::MODE_TX)
    `CHK(active, 1'b1)
    wr(rrs_pkg::REG_CTRL, 32'h0000_0002);
    rdr(rrs_pkg::REG_STAT); `CHK(rd[3:0], 4'h0)
    wr(rrs_pkg::REG_SEQCFG, 32'h0000_0018);
    wr(rrs_pkg::REG_CTRL, 32'h0000_0001); tick(1); `CHK(mode, rrs_pkg::MODE_STDBY)
    pulse(11); `CHK(mode, rrs_pkg::MODE_STDBY)
    pulse(10); `CHK(mode, rrs_pkg::MODE_RX)
    wr(rrs_pkg::REG_CTRL, 32'h0000_0002); `CHK(mode, rrs_pkg::MODE_SLEEP)
    $display("test sequencer done");
    wr(rrs_pkg::REG_RXCFG, 32'h0000_0140); tick(2); `CHK(gman, 1'b1)
    `CHK(fgain, 3'h5)
    $display("test gain done");
    // manual receive mode, one wait unit pair, FIFO held full at first
    wr(rrs_pkg::REG_MODE, 32'h0000_0005);
    wr(rrs_pkg::REG_WAIT, 32'h0000_0002);
    wr(rrs_pkg::REG_RXCFG, 32'h0000_0200);
    fe <= 1'b0;
    s0 = n_rst;
    pulse(3); tick(100); `CHK(n_rst, s0)
    fe <= 1'b1;
    tick(60); `CHK(n_rst, s0)
    tick(40); `CHK(n_rst, s0 + 1)
    wr(rrs_pkg::REG_WAIT, 32'h0000_0000);
    wr(rrs_pkg::REG_RXCFG, 32'h0000_0400);
    s1 = n_rl;
    pulse(3); tick(2300); `CHK(n_rl, s1)
    tick(200); `CHK(n_rl, s1 + 1)
    $display("test auto restart done");
    test_done;
  end
endmodule
